// ===== sbc_cfg_pkg.sv
package sbc_cfg_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;

   // register offsets (7-bit spi address)
   localparam logic [6:0] ADDR_HW_CONTROL_TWO = 7'h0F;
   localparam logic [6:0] ADDR_PIN_FUNCTION_SELECT = 7'h17;
   localparam logic [6:0] ADDR_PULSE_DUTY_SETTING = 7'h18;
   localparam logic [6:0] ADDR_PULSE_FREQUENCY_SETTING = 7'h1C;

   // reset values
   localparam logic [7:0] RST_HW_CONTROL_TWO = 8'h40;
   localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h00;
   localparam logic [7:0] RST_PULSE_DUTY_SETTING = 8'h00;
   localparam logic [7:0] RST_PULSE_FREQUENCY_SETTING = 8'h00;

   // field positions
   localparam int unsigned SW_FREQ_MSB = 7;
   localparam int unsigned SW_FREQ_LSB = 5;
   localparam int unsigned PEAK_TH_BIT = 4;
   localparam int unsigned SPREAD_MSB = 3;
   localparam int unsigned SPREAD_LSB = 2;
   localparam int unsigned LOCK_ONE_BIT = 0;
   localparam int unsigned PIN_FN_MSB = 2;
   localparam int unsigned RATE_MSB = 1;

   // spi frame layout, lsb first: address, write flag, then data byte
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned WR_FLAG_BIT = 7;

   // pin function codes
   localparam logic [2:0] PIN_FN_FAIL_A = 3'h0;
   localparam logic [2:0] PIN_FN_FAIL_B = 3'h1;
   localparam logic [2:0] PIN_FN_FAIL_C = 3'h2;
   localparam logic [2:0] PIN_FN_HS_TIMER = 3'h3;
   localparam logic [2:0] PIN_FN_OFF = 3'h4;
   localparam logic [2:0] PIN_FN_WAKE = 3'h5;
   localparam logic [2:0] PIN_FN_LS_PWM = 3'h6;
   localparam logic [2:0] PIN_FN_HS_PWM = 3'h7;

   // pwm: one period is 255 steps
   localparam int unsigned PWM_STEPS = 255;
   localparam int unsigned PWM_HZ_0 = 100;
   localparam int unsigned PWM_HZ_1 = 200;
   localparam int unsigned PWM_HZ_2 = 325;
   localparam int unsigned PWM_HZ_3 = 400;
   // cycles per step, rounded to nearest
   localparam logic [11:0] STEP_CYC_0 = 12'((CLK_HZ + PWM_HZ_0 * PWM_STEPS / 2) / (PWM_HZ_0 * PWM_STEPS));
   localparam logic [11:0] STEP_CYC_1 = 12'((CLK_HZ + PWM_HZ_1 * PWM_STEPS / 2) / (PWM_HZ_1 * PWM_STEPS));
   localparam logic [11:0] STEP_CYC_2 = 12'((CLK_HZ + PWM_HZ_2 * PWM_STEPS / 2) / (PWM_HZ_2 * PWM_STEPS));
   localparam logic [11:0] STEP_CYC_3 = 12'((CLK_HZ + PWM_HZ_3 * PWM_STEPS / 2) / (PWM_HZ_3 * PWM_STEPS));

   // wake filter, least time rounds up
   localparam int unsigned WAKE_FILT_NS = 16_000;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam logic [9:0] WAKE_FILT_CYC = 10'((WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : sbc_cfg_pkg

// ===== sbc_cfg_regs.sv
`timescale 1ns/1ns
`default_nettype none
module sbc_cfg_regs
   import sbc_cfg_pkg::*;
(
   // clock and power-on reset
   input wire logic clk,
   input wire logic nrst,
   // spi pins
   input wire logic spi_csn,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // device mode events, same clock domain
   input wire logic soft_reset,
   input wire logic restart_entry,
   input wire logic long_delay_done,
   input wire logic restart_from_powerup,
   input wire logic failsafe_mode,
   input wire logic cfg_lock_zero,
   // general purpose high-voltage pin
   input wire logic gpio_pin_in,
   // decoded configuration
   output logic [2:0] switching_freq_sel,
   output logic peak_current_thresh_sel,
   output logic [1:0] spread_mod_freq_sel,
   output logic spread_enable,
   output logic cfg_lock_one_active,
   output logic fail_output_sel,
   output logic hs_timer_sel,
   output logic pin_off_sel,
   output logic wake_input_sel,
   output logic ls_pwm_drive,
   output logic hs_pwm_drive,
   output logic wake_level,
   output logic wake_event,
   output logic wake_default_source,
   output logic pwm_out
);

   logic [7:0] hw_control_two;
   logic [2:0] pin_function;
   logic [7:0] duty_setting;
   logic [1:0] pulse_rate_sel;

   // restart value of the pin field: switching functions fall back to off
   function automatic logic [2:0] pin_restart_value(input logic [2:0] fn);
      case (fn)
         PIN_FN_HS_TIMER, PIN_FN_LS_PWM, PIN_FN_HS_PWM: pin_restart_value = PIN_FN_OFF;
         default: pin_restart_value = fn;
      endcase
   endfunction : pin_restart_value

   function automatic logic [11:0] step_cycles(input logic [1:0] sel);
      case (sel)
         2'h0: step_cycles = STEP_CYC_0;
         2'h1: step_cycles = STEP_CYC_1;
         2'h2: step_cycles = STEP_CYC_2;
         default: step_cycles = STEP_CYC_3;
      endcase
   endfunction : step_cycles

   // spi slave: pins cross two flip-flops, edges are found on the synchronised copies
   logic [2:0] csn_sync;
   logic [2:0] sclk_sync;
   logic [1:0] mosi_sync;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         csn_sync <= 3'h7;
         sclk_sync <= 3'h0;
         mosi_sync <= 2'h0;
      end else begin
         csn_sync <= {csn_sync[1:0], spi_csn};
         sclk_sync <= {sclk_sync[1:0], spi_sclk};
         mosi_sync <= {mosi_sync[0], spi_mosi};
      end
   end

   logic csn_low;
   logic sclk_rise;
   logic sclk_fall;
   logic frame_end;
   assign csn_low = ~csn_sync[1];
   assign sclk_rise = csn_low && sclk_sync[1] && !sclk_sync[2];
   assign sclk_fall = csn_low && !sclk_sync[1] && sclk_sync[2];
   assign frame_end = csn_sync[1] && !csn_sync[2];

   logic [15:0] rx_shift;
   logic [4:0] bit_cnt;
   logic [7:0] tx_shift;
   logic [7:0] read_data;

   // after eight rising edges the address sits in bits 14:8 and the write flag in bit 15
   always_comb begin
      case (rx_shift[14:8])
         ADDR_HW_CONTROL_TWO: read_data = hw_control_two;
         ADDR_PIN_FUNCTION_SELECT: read_data = {5'h00, pin_function};
         ADDR_PULSE_DUTY_SETTING: read_data = duty_setting;
         ADDR_PULSE_FREQUENCY_SETTING: read_data = {6'h00, pulse_rate_sel};
         default: read_data = 8'h00;
      endcase
   end

   // frame bits arrive lsb first and shift in from the top
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_shift <= 16'h0000;
         bit_cnt <= 5'h00;
      end else if (!csn_low) begin
         bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
         rx_shift <= {mosi_sync[1], rx_shift[15:1]};
         if (bit_cnt != 5'h1F)
            bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // read data is loaded once the address byte is complete, shifted on falling edges
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_shift <= 8'h00;
      end else if (!csn_low) begin
         tx_shift <= 8'h00;
      end else if (sclk_rise && bit_cnt == 5'h07) begin
         tx_shift <= 8'h00;
      end else if (bit_cnt == 5'h08 && sclk_sync[1]) begin
         tx_shift <= read_data;
      end else if (sclk_fall && bit_cnt > 5'h08) begin
         tx_shift <= {1'b0, tx_shift[7:1]};
      end
   end

   // registered so miso only moves a few clocks after a falling sclk is seen
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         spi_miso <= 1'b0;
      else
         spi_miso <= tx_shift[0];
   end
   assign spi_miso_oe = csn_low;

   // writes commit only at the end of a complete 16-bit frame
   // a frame cut short or overrun leaves bit_cnt away from 16 and writes nothing
   logic wr_commit;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   assign wr_addr = rx_shift[6:0];
   assign wr_data = rx_shift[15:8];
   assign wr_commit = frame_end && bit_cnt == 5'(FRAME_BITS) && rx_shift[WR_FLAG_BIT];

   // hardware control two
   // lock sampled before the frame commits, so the frame that sets it still writes freely
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hw_control_two <= RST_HW_CONTROL_TWO;
      end else if (soft_reset) begin
         if (!cfg_lock_one_active)
            hw_control_two <= RST_HW_CONTROL_TWO;
      end else if (long_delay_done && restart_from_powerup && !cfg_lock_one_active) begin
         hw_control_two <= RST_HW_CONTROL_TWO;
      end else if (wr_commit && wr_addr == ADDR_HW_CONTROL_TWO && !cfg_lock_one_active) begin
         hw_control_two[SW_FREQ_MSB:SW_FREQ_LSB] <= wr_data[SW_FREQ_MSB:SW_FREQ_LSB];
         hw_control_two[PEAK_TH_BIT] <= wr_data[PEAK_TH_BIT];
         hw_control_two[SPREAD_MSB:SPREAD_LSB] <= wr_data[SPREAD_MSB:SPREAD_LSB];
         hw_control_two[LOCK_ONE_BIT] <= wr_data[LOCK_ONE_BIT];
         hw_control_two[1] <= 1'b0;
      end
   end

   // lock becomes active at the chip select edge that closes the frame
   // only power-on reset clears it; soft reset and restart leave it alone
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         cfg_lock_one_active <= 1'b0;
      else if (wr_commit && wr_addr == ADDR_HW_CONTROL_TWO && wr_data[LOCK_ONE_BIT])
         cfg_lock_one_active <= 1'b1;
   end

   // reserved switching codes pass through; the regulator side decides what they mean
   assign switching_freq_sel = hw_control_two[SW_FREQ_MSB:SW_FREQ_LSB];
   assign peak_current_thresh_sel = hw_control_two[PEAK_TH_BIT];
   assign spread_mod_freq_sel = hw_control_two[SPREAD_MSB:SPREAD_LSB];
   assign spread_enable = |spread_mod_freq_sel;

   // pin function
   // level-1 lock does not cover this field; only level-0 does
   // restart parks switching functions at off so a stale drive cannot resume
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_function <= RST_PIN_FUNCTION_SELECT[PIN_FN_MSB:0];
      end else if (soft_reset) begin
         if (cfg_lock_zero)
            pin_function <= pin_restart_value(pin_function);
         else
            pin_function <= RST_PIN_FUNCTION_SELECT[PIN_FN_MSB:0];
      end else if (restart_entry) begin
         pin_function <= pin_restart_value(pin_function);
      end else if (wr_commit && wr_addr == ADDR_PIN_FUNCTION_SELECT && !cfg_lock_zero) begin
         pin_function <= wr_data[PIN_FN_MSB:0];
      end
   end

   always_comb begin
      fail_output_sel = 1'b0;
      hs_timer_sel = 1'b0;
      pin_off_sel = 1'b0;
      wake_input_sel = 1'b0;
      ls_pwm_drive = 1'b0;
      hs_pwm_drive = 1'b0;
      case (pin_function)
         PIN_FN_FAIL_A, PIN_FN_FAIL_B, PIN_FN_FAIL_C: fail_output_sel = 1'b1;
         PIN_FN_HS_TIMER: hs_timer_sel = 1'b1;
         PIN_FN_OFF: pin_off_sel = 1'b1;
         PIN_FN_WAKE: wake_input_sel = 1'b1;
         PIN_FN_LS_PWM: ls_pwm_drive = pwm_out;
         PIN_FN_HS_PWM: hs_pwm_drive = pwm_out;
         default: pin_off_sel = 1'b1;
      endcase
   end

   assign wake_default_source = wake_input_sel && failsafe_mode;

   // wake filter
   logic [1:0] pin_sync;
   logic [9:0] filt_cnt;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         pin_sync <= 2'h0;
      else
         pin_sync <= {pin_sync[0], gpio_pin_in};
   end

   // a level must stand unchanged for the whole filter time before it is taken
   // any glitch back to the taken level clears the count, so the wait starts over
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         filt_cnt <= 10'h000;
         wake_level <= 1'b0;
         wake_event <= 1'b0;
      end else begin
         wake_event <= 1'b0;
         if (!wake_input_sel || pin_sync[1] == wake_level) begin
            filt_cnt <= 10'h000;
         end else if (filt_cnt == WAKE_FILT_CYC - 10'h001) begin
            filt_cnt <= 10'h000;
            wake_level <= pin_sync[1];
            wake_event <= 1'b1;
         end else begin
            filt_cnt <= filt_cnt + 10'h001;
         end
      end
   end

   // pwm registers: soft reset clears duty and rate, restart entry keeps them
   // the generator only picks these up at a period boundary
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         duty_setting <= RST_PULSE_DUTY_SETTING;
      end else if (soft_reset) begin
         duty_setting <= RST_PULSE_DUTY_SETTING;
      end else if (wr_commit && wr_addr == ADDR_PULSE_DUTY_SETTING) begin
         duty_setting <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pulse_rate_sel <= RST_PULSE_FREQUENCY_SETTING[RATE_MSB:0];
      end else if (soft_reset) begin
         pulse_rate_sel <= RST_PULSE_FREQUENCY_SETTING[RATE_MSB:0];
      end else if (wr_commit && wr_addr == ADDR_PULSE_FREQUENCY_SETTING) begin
         pulse_rate_sel <= wr_data[RATE_MSB:0];
      end
   end

   // pwm generator, free-running from reset
   // a full period at the fastest rate outlasts a short test run
   logic [7:0] active_duty;
   logic [1:0] active_rate;
   logic [11:0] step_div;
   logic [7:0] step_idx;
   logic step_tick;
   logic period_end;
   assign step_tick = step_div == step_cycles(active_rate) - 12'h001;
   assign period_end = step_tick && step_idx == 8'(PWM_STEPS - 1);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         step_div <= 12'h000;
         step_idx <= 8'h00;
      end else if (step_tick) begin
         step_div <= 12'h000;
         step_idx <= period_end ? 8'h00 : step_idx + 8'h01;
      end else begin
         step_div <= step_div + 12'h001;
      end
   end

   // settings are sampled only at the period boundary so no period is cut short
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         active_duty <= RST_PULSE_DUTY_SETTING;
         active_rate <= RST_PULSE_FREQUENCY_SETTING[RATE_MSB:0];
      end else if (period_end) begin
         active_duty <= duty_setting;
         active_rate <= pulse_rate_sel;
      end
   end

   // step < duty gives duty/255 on-time; 0 never on, 255 covers every step
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         pwm_out <= 1'b0;
      else
         pwm_out <= step_idx < active_duty;
   end
endmodule : sbc_cfg_regs
`default_nettype wire

// ===== sbc_cfg_props.sv
`timescale 1ns/1ns
`default_nettype none
module sbc_cfg_props (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // watched inputs
   input wire logic spi_csn,
   input wire logic gpio_pin_in,
   input wire logic failsafe_mode,
   // watched outputs
   input wire logic spi_miso_oe,
   input wire logic [2:0] switching_freq_sel,
   input wire logic peak_current_thresh_sel,
   input wire logic [1:0] spread_mod_freq_sel,
   input wire logic spread_enable,
   input wire logic cfg_lock_one_active,
   input wire logic fail_output_sel,
   input wire logic hs_timer_sel,
   input wire logic pin_off_sel,
   input wire logic wake_input_sel,
   input wire logic ls_pwm_drive,
   input wire logic hs_pwm_drive,
   input wire logic wake_level,
   input wire logic wake_event,
   input wire logic wake_default_source,
   input wire logic pwm_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // cycles the raw pin has held its level; saturates so long idle stays legal
   logic [9:0] same_cnt;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) same_cnt <= 10'h000;
      else if ($changed(gpio_pin_in)) same_cnt <= 10'h000;
      else if (same_cnt != 10'h3FF) same_cnt <= same_cnt + 10'h001;
   end
   AST_SPREAD_FLAG: assert property (spread_enable == (spread_mod_freq_sel != 2'h0))
      else $error("spread flag disagrees with field");
   AST_FIELDS_LOCKED: assert property (cfg_lock_one_active |=>
      $stable({switching_freq_sel, peak_current_thresh_sel, spread_mod_freq_sel}))
      else $error("locked field changed");
   AST_LOCK_HELD: assert property (cfg_lock_one_active |=> cfg_lock_one_active)
      else $error("lock released");
   AST_LOCK_AFTER_CS: assert property ($rose(cfg_lock_one_active) |-> spi_csn && $past(spi_csn))
      else $error("lock applied inside frame");
   AST_FAIL_EXCL: assert property (fail_output_sel |-> !(hs_timer_sel || pin_off_sel || wake_input_sel))
      else $error("pin decode overlap");
   AST_PWM_GATE: assert property ((ls_pwm_drive || hs_pwm_drive) |-> pwm_out &&
      !(ls_pwm_drive && hs_pwm_drive) && !fail_output_sel && !wake_input_sel)
      else $error("pwm drive without pwm function");
   AST_WAKE_SRC: assert property (wake_default_source == (wake_input_sel && failsafe_mode))
      else $error("default wake source wrong");
   AST_WAKE_FILTER: assert property ($changed(wake_level) |-> same_cnt >= 10'h31F && wake_level == gpio_pin_in)
      else $error("wake level changed before filter time");
   AST_WAKE_EVENT: assert property (wake_event |-> wake_input_sel)
      else $error("wake event while pin not a wake input");
   AST_MISO_IDLE: assert property (spi_csn [*3] |=> !spi_miso_oe)
      else $error("miso driven while deselected");
   cover property ($rose(cfg_lock_one_active));
   cover property (wake_event);
   cover property (hs_timer_sel);
   cover property (wake_default_source);
endmodule : sbc_cfg_props
bind sbc_cfg_regs sbc_cfg_props u_props (.*);
`default_nettype wire

// ===== sbc_spi_master.sv
`timescale 1ns/1ns
`default_nettype none
module sbc_spi_master (
   // bench side
   input wire logic clk,
   input wire logic req,
   input wire logic [15:0] frame,
   output logic done,
   output logic [7:0] rdata,
   // spi pins
   output logic spi_csn,
   output logic spi_sclk,
   output logic spi_mosi,
   input wire logic spi_miso
);
   // six clocks per half leaves margin over the four-clock miso lag
   localparam int HALF = 6;
   initial begin
      {spi_csn, spi_sclk, spi_mosi, done, rdata} = 12'h800;
   end
   always begin
      @(posedge clk);
      if (req && !done) begin
         spi_csn <= 1'b0;
         for (int i = 0; i < 16; i++) begin
            spi_mosi <= frame[i];
            repeat (HALF) @(posedge clk);
            if (i >= 8) rdata[i - 8] <= spi_miso;
            spi_sclk <= 1'b1;
            repeat (HALF) @(posedge clk);
            spi_sclk <= 1'b0;
         end
         repeat (HALF) @(posedge clk);
         spi_csn <= 1'b1;
         // released line must not keep looking like valid data
         spi_mosi <= ~spi_mosi;
         repeat (8) @(posedge clk);
         done <= 1'b1;
      end else begin
         done <= 1'b0;
      end
   end
endmodule : sbc_spi_master
`default_nettype wire

// ===== sbc_cfg_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sbc_cfg_regs_bench
   import sbc_cfg_pkg::*;
   ;
   logic clk = 1'b0, nrst = 1'b0, soft_reset = 1'b0, restart_entry = 1'b0, long_delay_done = 1'b0;
   logic restart_from_powerup = 1'b0, failsafe_mode = 1'b0, cfg_lock_zero = 1'b0, gpio_pin_in = 1'b0;
   logic spi_csn, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, done, req = 1'b0;
   logic peak_current_thresh_sel, spread_enable, cfg_lock_one_active, fail_output_sel, hs_timer_sel;
   logic pin_off_sel, wake_input_sel, ls_pwm_drive, hs_pwm_drive, wake_level, wake_event;
   logic wake_default_source, pwm_out;
   logic [2:0] switching_freq_sel;
   logic [1:0] spread_mod_freq_sel;
   logic [15:0] frame = 16'h0000;
   logic [7:0] rdata;
   int failures = 0, cmp_count = 0, events = 0;
   int mdl[int];
   int unsigned seed = 2;
   bit lock = 0;
   sbc_cfg_regs dut (.*);
   sbc_spi_master u_mst (.*);
   always #10 clk = ~clk;
   always @(posedge clk) if (wake_event === 1'b1) events++;
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic xfer(input logic [15:0] f);
      int n;
      n = 0;
      frame <= f;
      req <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 2000);
      req <= 1'b0;
      // let an edge pass so the next request never rewrites req in this time step
      @(posedge clk);
      if (n >= 2000) begin
         failures++;
         summarize();
      end
   endtask : xfer
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      xfer({d, 1'b1, a});
      case (a)
         ADDR_HW_CONTROL_TWO: if (!lock) begin
            mdl[a] = d & 8'hFD;
            lock = d[0];
         end
         ADDR_PIN_FUNCTION_SELECT: if (!cfg_lock_zero) mdl[a] = d & 8'h07;
         ADDR_PULSE_DUTY_SETTING: mdl[a] = d;
         ADDR_PULSE_FREQUENCY_SETTING: mdl[a] = d & 8'h03;
         default: ;
      endcase
   endtask : wr
   task automatic rd(input logic [6:0] a);
      xfer({8'h00, 1'b0, a});
      check(rdata, 8'(mdl.exists(a) ? mdl[a] : 0));
   endtask : rd
   task automatic hw(input logic [7:0] d);
      wr(ADDR_HW_CONTROL_TWO, d);
      rd(ADDR_HW_CONTROL_TWO);
      check({switching_freq_sel, peak_current_thresh_sel, spread_mod_freq_sel, 1'b0, cfg_lock_one_active},
         8'(mdl[ADDR_HW_CONTROL_TWO]));
      check({7'h00, spread_enable}, {7'h00, (mdl[ADDR_HW_CONTROL_TWO] & 12) != 0});
   endtask : hw
   // 0 soft reset, 1 restart entry, 2 long delay done
   task automatic ev(input int k);
      soft_reset <= (k == 0);
      restart_entry <= (k == 1);
      long_delay_done <= (k == 2);
      @(posedge clk);
      {soft_reset, restart_entry, long_delay_done} <= 3'h0;
      repeat (3) @(posedge clk);
   endtask : ev
   initial begin
      mdl[ADDR_HW_CONTROL_TWO] = RST_HW_CONTROL_TWO;
      mdl[ADDR_PIN_FUNCTION_SELECT] = RST_PIN_FUNCTION_SELECT;
      mdl[ADDR_PULSE_DUTY_SETTING] = RST_PULSE_DUTY_SETTING;
      mdl[ADDR_PULSE_FREQUENCY_SETTING] = RST_PULSE_FREQUENCY_SETTING;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (mdl[a]) rd(7'(a));
      rd(7'h10);
      wr(ADDR_PULSE_DUTY_SETTING, 8'(xs()));
      rd(ADDR_PULSE_DUTY_SETTING);
      wr(ADDR_PULSE_FREQUENCY_SETTING, 8'(xs()));
      rd(ADDR_PULSE_FREQUENCY_SETTING);
      wr(ADDR_PULSE_DUTY_SETTING, 8'hFF);
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_PIN_FUNCTION_SELECT, 8'(c) | 8'hF8);
         rd(ADDR_PIN_FUNCTION_SELECT);
         check({2'h0, fail_output_sel, hs_timer_sel, pin_off_sel, wake_input_sel, ls_pwm_drive, hs_pwm_drive},
            {2'h0, c < 3, c == 3, c == 4, c == 5, 2'h0});
      end
      wr(ADDR_PIN_FUNCTION_SELECT, 8'h05);
      gpio_pin_in <= 1'b1;
      repeat (300) @(posedge clk);
      gpio_pin_in <= 1'b0;
      repeat (20) @(posedge clk);
      check({7'h00, wake_level}, 8'h00);
      gpio_pin_in <= 1'b1;
      repeat (820) @(posedge clk);
      failsafe_mode <= 1'b1;
      repeat (2) @(posedge clk);
      check({6'h00, wake_level, wake_default_source}, 8'h03);
      check(8'(events), 8'h01);
      wr(ADDR_PIN_FUNCTION_SELECT, 8'h03);
      ev(1);
      mdl[ADDR_PIN_FUNCTION_SELECT] = 4;
      rd(ADDR_PIN_FUNCTION_SELECT);
      rd(ADDR_PULSE_DUTY_SETTING);
      cfg_lock_zero <= 1'b1;
      wr(ADDR_PIN_FUNCTION_SELECT, 8'h01);
      rd(ADDR_PIN_FUNCTION_SELECT);
      ev(0);
      mdl[ADDR_PULSE_DUTY_SETTING] = 0;
      mdl[ADDR_PULSE_FREQUENCY_SETTING] = 0;
      foreach (mdl[a]) if (a != ADDR_HW_CONTROL_TWO) rd(7'(a));
      cfg_lock_zero <= 1'b0;
      for (int k = 0; k < 16; k++) hw({1'b0, k[3:2], k[0], k[1:0], 2'h2});
      ev(2);
      rd(ADDR_HW_CONTROL_TWO);
      restart_from_powerup <= 1'b1;
      ev(2);
      mdl[ADDR_HW_CONTROL_TWO] = 8'h40;
      rd(ADDR_HW_CONTROL_TWO);
      hw(8'h75);
      hw(8'h00);
      wr(ADDR_PIN_FUNCTION_SELECT, 8'h07);
      ev(0);
      mdl[ADDR_PIN_FUNCTION_SELECT] = 0;
      ev(2);
      hw(8'h02);
      foreach (mdl[a]) rd(7'(a));
      check({7'h00, pwm_out}, 8'h00);
      summarize();
   end
endmodule : sbc_cfg_regs_bench
`default_nettype wire
